// ==== logic/dcp_pkg.sv ====
// dcp_pkg: register map, field layout, reset values and spread tables for the receiver config block
// assumes a 32-bit axi4-lite host and a parallel clock equal to aclk
package dcp_pkg;
  localparam logic [7:0] OFS_EQ_CFG = 8'h00;
  localparam logic [7:0] OFS_OUT_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  // eq_cfg fields
  localparam int EQ_SEL_LSB = 0;
  localparam int EQ_TEST_OUT_BIT = 4;
  // out_cfg fields
  localparam int OUT_CLK_SLEW_BIT = 0;
  localparam int OUT_DATA_SLEW_BIT = 1;
  localparam int OUT_OSS_BIT = 2;
  localparam int OUT_LF_BIT = 3;
  localparam int OUT_SPREAD_LSB = 4;
  // status fields
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_POWERED_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_EQ_EN_BIT = 3;
  localparam int ST_EQ_STEP_LSB = 4;
  localparam int ST_DEV_STEP_LSB = 8;
  localparam int ST_SPREAD_EN_BIT = 10;
  localparam int ST_DIV_LSB = 16;
  // reset values
  localparam logic [3:0] RST_EQ_SEL = 4'h0;
  localparam logic RST_TEST_OUT = 1'b0;
  localparam logic RST_SLEW = 1'b0;
  localparam logic RST_OSS = 1'b0;
  localparam logic RST_LF = 1'b0;
  localparam logic [3:0] RST_SPREAD = 4'h0;
  // modulation dividers, low-frequency mode off, by code group
  localparam logic [11:0] DIV_HF_G0 = 12'd2168;
  localparam logic [11:0] DIV_HF_G1 = 12'd1300;
  localparam logic [11:0] DIV_HF_G2 = 12'd868;
  localparam logic [11:0] DIV_HF_G3 = 12'd650;
  // low-frequency mode on
  localparam logic [11:0] DIV_LF_G0 = 12'd620;
  localparam logic [11:0] DIV_LF_G1 = 12'd370;
  localparam logic [11:0] DIV_LF_G2 = 12'd258;
  localparam logic [11:0] DIV_LF_G3 = 12'd192;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int PIN_W = 15;
  typedef enum logic [2:0] {
    ST_PDOWN = 3'b000,
    ST_STRAP = 3'b001,
    ST_ACQUIRE = 3'b011,
    ST_LOCKED = 3'b010,
    ST_SLEEP = 3'b110
  } dcp_state_t;
endpackage : dcp_pkg

// ==== logic/dcp_sync.sv ====
// dcp_sync: three-stage pin synchroniser; output follows once stages two and three agree
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ps
module dcp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins in, clean levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dcp_sync_t;
  dcp_sync_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // per bit: only a value held for two samples passes
    st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule : dcp_sync

// ==== logic/dcp_cfg_power.sv ====
// dcp_cfg_power: configuration and power-state control for the receiving end of a serial link
// assumes aclk is the parallel clock; the recovery loop and pads live outside and report by pins
`timescale 1ns/1ps
module dcp_cfg_power
  import dcp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins: power, stream and strap inputs
  input wire logic power_enable_n,
  input wire logic stream_clock_present,
  input wire logic recovery_locked,
  input wire logic [3:0] strap_equalizer_select,
  input wire logic strap_clock_out_slew_select,
  input wire logic strap_data_out_slew_select,
  input wire logic [3:0] strap_spread_setting,
  input wire logic strap_low_freq_spread_mode,
  input wire logic strap_output_state_select,
  // recovered parallel word
  input wire logic [23:0] recovered_data,
  input wire logic [2:0] recovered_control,
  // analog controls
  output logic equalizer_enable,
  output logic [2:0] equalizer_gain_step,
  output logic serial_test_out_enable,
  output logic clock_out_slew_select,
  output logic data_out_slew_select,
  output logic spread_enable,
  output logic [1:0] spread_dev_step,
  output logic [11:0] spread_divider,
  output logic spread_mod_phase,
  output logic receiver_sleep,
  // parallel outputs with enables
  output logic [23:0] data_out,
  output logic [2:0] control_out,
  output logic data_out_oe,
  output logic recovered_clock_out_oe,
  output logic recovered_clock_out_run,
  output logic lock_out,
  output logic pass_out,
  output logic status_out_oe
);
  typedef struct packed {
    dcp_state_t state;
    logic [3:0] eq_sel;
    logic test_out;
    logic clk_slew;
    logic data_slew;
    logic oss;
    logic lf;
    logic [3:0] spread;
    logic [11:0] mod_cnt;
    logic mod_phase;
    logic [23:0] dout;
    logic [2:0] cout;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcp_core_t;
  dcp_core_t st_r, st_nxt;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins;
  logic pwr_on;
  logic stream_ok;
  logic cdr_lock;
  logic [3:0] code_m1;
  logic [11:0] div_sel;
  logic [31:0] status_word;

  // pin order: enable, stream, lock, eq select, two slews, spread code, lf, oss
  assign pins_raw = {power_enable_n, stream_clock_present, recovered_locked_pad(recovery_locked),
    strap_equalizer_select, strap_clock_out_slew_select, strap_data_out_slew_select,
    strap_spread_setting, strap_low_freq_spread_mode, strap_output_state_select};

  function automatic logic recovered_locked_pad(input logic v);
    recovered_locked_pad = v;
  endfunction : recovered_locked_pad

  dcp_sync #(.W(PIN_W)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(pins_raw),
    .q(pins)
  );

  // pin enable is active high despite its name: low means power down
  assign pwr_on = pins[14];
  assign stream_ok = pins[13];
  assign cdr_lock = pins[12];

  // spread code decode: codes 1-4, 5-8 and 9-12 share one divider per group, codes 13-15 the last
  assign code_m1 = st_r.spread - 4'h1;
  always_comb begin
    div_sel = DIV_HF_G0;
    if (st_r.lf) begin
      case (code_m1[3:2])
        2'd0: div_sel = DIV_LF_G0;
        2'd1: div_sel = DIV_LF_G1;
        2'd2: div_sel = DIV_LF_G2;
        default: div_sel = DIV_LF_G3;
      endcase
    end else begin
      case (code_m1[3:2])
        2'd0: div_sel = DIV_HF_G0;
        2'd1: div_sel = DIV_HF_G1;
        2'd2: div_sel = DIV_HF_G2;
        default: div_sel = DIV_HF_G3;
      endcase
    end
  end

  // steps and divider read back as driven, so a disabled feature reads zero
  always_comb begin
    status_word = '0;
    status_word[ST_LOCK_BIT] = (st_r.state == ST_LOCKED);
    status_word[ST_POWERED_BIT] = (st_r.state != ST_PDOWN);
    status_word[ST_SLEEP_BIT] = (st_r.state == ST_SLEEP);
    status_word[ST_EQ_EN_BIT] = st_r.eq_sel[0];
    status_word[ST_EQ_STEP_LSB +: 3] = equalizer_gain_step;
    status_word[ST_DEV_STEP_LSB +: 2] = spread_dev_step;
    status_word[ST_SPREAD_EN_BIT] = (st_r.spread != 4'h0);
    status_word[ST_DIV_LSB +: 12] = spread_divider;
  end

  always_comb begin
    st_nxt = st_r;
    // power state sequencing
    case (st_r.state)
      ST_PDOWN: begin
        if (pwr_on) begin
          st_nxt.state = ST_STRAP;
        end
      end
      ST_STRAP: begin
        // straps are sampled once here; later writes win until the next power down
        st_nxt.eq_sel = pins[11:8];
        st_nxt.clk_slew = pins[7];
        st_nxt.data_slew = pins[6];
        st_nxt.spread = pins[5:2];
        st_nxt.lf = pins[1];
        st_nxt.oss = pins[0];
        st_nxt.state = ST_ACQUIRE;
      end
      ST_ACQUIRE: begin
        if (!stream_ok) begin
          st_nxt.state = ST_SLEEP;
        end else if (cdr_lock) begin
          st_nxt.state = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (!stream_ok || !cdr_lock) begin
          st_nxt.state = stream_ok ? ST_ACQUIRE : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // registers untouched here, unlike power down
        if (stream_ok) begin
          st_nxt.state = ST_ACQUIRE;
        end
      end
      default: st_nxt.state = ST_PDOWN;
    endcase
    if (!pwr_on) begin
      st_nxt.state = ST_PDOWN;
    end

    // parallel word passes only while locked; otherwise held low
    if (st_r.state == ST_LOCKED) begin
      st_nxt.dout = recovered_data;
      st_nxt.cout = recovered_control;
    end else begin
      st_nxt.dout = '0;
      st_nxt.cout = '0;
    end

    // modulation profile: phase flips every divider count of the parallel clock
    // compare with >= so a shorter divider written mid-count cannot overrun
    if (st_r.spread == 4'h0 || st_r.state != ST_LOCKED) begin
      st_nxt.mod_cnt = '0;
      st_nxt.mod_phase = 1'b0;
    end else if (st_r.mod_cnt >= div_sel - 12'd1) begin
      st_nxt.mod_cnt = '0;
      st_nxt.mod_phase = !st_r.mod_phase;
    end else begin
      st_nxt.mod_cnt = st_r.mod_cnt + 12'd1;
    end

    // axi write path: address and data taken in either order
    // in power down a write is answered, but the reset override below undoes it
    if (s_axi_awvalid && s_axi_awready) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_nxt.w_have = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (st_r.awaddr & 8'hFC)
        OFS_EQ_CFG: begin
          if (st_r.wstrb[0]) begin
            st_nxt.eq_sel = st_r.wdata[EQ_SEL_LSB +: 4];
            st_nxt.test_out = st_r.wdata[EQ_TEST_OUT_BIT];
          end
        end
        OFS_OUT_CFG: begin
          if (st_r.wstrb[0]) begin
            st_nxt.clk_slew = st_r.wdata[OUT_CLK_SLEW_BIT];
            st_nxt.data_slew = st_r.wdata[OUT_DATA_SLEW_BIT];
            st_nxt.oss = st_r.wdata[OUT_OSS_BIT];
            st_nxt.lf = st_r.wdata[OUT_LF_BIT];
            st_nxt.spread = st_r.wdata[OUT_SPREAD_LSB +: 4];
          end
        end
        OFS_STATUS: st_nxt.bresp = RESP_OKAY;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // axi read path
    if (s_axi_arvalid && s_axi_arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (s_axi_araddr & 8'hFC)
        OFS_EQ_CFG: st_nxt.rdata = {27'h0, st_r.test_out, st_r.eq_sel};
        OFS_OUT_CFG: st_nxt.rdata = {24'h0, st_r.spread, st_r.lf, st_r.oss, st_r.data_slew, st_r.clk_slew};
        OFS_STATUS: st_nxt.rdata = status_word;
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // power down wins over any write landing in the same cycle
    if (st_r.state == ST_PDOWN || !pwr_on) begin
      st_nxt.eq_sel = RST_EQ_SEL;
      st_nxt.test_out = RST_TEST_OUT;
      st_nxt.clk_slew = RST_SLEW;
      st_nxt.data_slew = RST_SLEW;
      st_nxt.oss = RST_OSS;
      st_nxt.lf = RST_LF;
      st_nxt.spread = RST_SPREAD;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.state <= ST_PDOWN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bus handshakes: one write and one read outstanding
  // awready drops while bvalid stands, so a second write waits for its response
  assign s_axi_awready = !st_r.aw_have && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_have && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // analog steering
  assign equalizer_enable = st_r.eq_sel[0];
  assign equalizer_gain_step = st_r.eq_sel[0] ? st_r.eq_sel[3:1] : 3'h0;
  assign serial_test_out_enable = st_r.test_out && st_r.eq_sel[0];
  assign clock_out_slew_select = st_r.clk_slew;
  assign data_out_slew_select = st_r.data_slew;
  assign spread_enable = (st_r.spread != 4'h0);
  assign spread_dev_step = spread_enable ? code_m1[1:0] : 2'h0;
  assign spread_divider = spread_enable ? div_sel : 12'h000;
  assign spread_mod_phase = st_r.mod_phase;
  assign receiver_sleep = (st_r.state == ST_SLEEP) || (st_r.state == ST_PDOWN);

  // output pin states: float when off, low or float on a static stream
  // lock and pass stay driven low on a static stream; only power down floats them
  assign data_out = st_r.dout;
  assign control_out = st_r.cout;
  assign status_out_oe = (st_r.state != ST_PDOWN);
  assign data_out_oe = (st_r.state == ST_LOCKED) || (st_r.state != ST_PDOWN && !st_r.oss);
  assign recovered_clock_out_oe = data_out_oe;
  assign recovered_clock_out_run = (st_r.state == ST_LOCKED);
  assign lock_out = (st_r.state == ST_LOCKED);
  assign pass_out = (st_r.state == ST_LOCKED);
endmodule : dcp_cfg_power

// ==== sim/dcp_ser_model.sv ====
// dcp_ser_model: far-end serializer as seen through the recovery loop
// assumes run is driven by the bench; stream, lock and word follow it
`timescale 1ns/1ps
module dcp_ser_model #(
  parameter int LOCK_DLY = 12
) (
  // clock and control
  input wire logic aclk,
  input wire logic run,
  // toward the receiver
  output logic stream_clock_present = 1'b0,
  output logic recovery_locked = 1'b0,
  output logic [23:0] recovered_data = 24'h0,
  output logic [2:0] recovered_control = 3'h0
);
  int cnt = 0;
  always @(posedge aclk) begin
    stream_clock_present <= run;
    cnt <= run ? (cnt < LOCK_DLY ? cnt + 1 : cnt) : 0;
    // lock only after the stream has been steady a while
    recovery_locked <= run && cnt >= LOCK_DLY;
    // no stream means no valid word: keep it changing so a stale copy shows
    recovered_data <= run ? recovered_data + 24'h1 : ~recovered_data;
    recovered_control <= recovered_data[2:0] ^ 3'h5;
  end
endmodule : dcp_ser_model

// ==== sim/dcp_cfg_power_monitor.sv ====
// dcp_cfg_power_monitor: port assertions for the receiver config block
// assumes it is bound onto dcp_cfg_power; one clock domain
`timescale 1ns/1ps
module dcp_cfg_power_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched ports
  input wire logic [23:0] recovered_data,
  input wire logic [2:0] recovered_control,
  input wire logic equalizer_enable,
  input wire logic [2:0] equalizer_gain_step,
  input wire logic serial_test_out_enable,
  input wire logic spread_enable,
  input wire logic [1:0] spread_dev_step,
  input wire logic [11:0] spread_divider,
  input wire logic receiver_sleep,
  input wire logic [23:0] data_out,
  input wire logic [2:0] control_out,
  input wire logic spread_mod_phase,
  input wire logic recovered_clock_out_run,
  input wire logic data_out_oe,
  input wire logic recovered_clock_out_oe,
  input wire logic lock_out,
  input wire logic pass_out,
  input wire logic status_out_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_locked2;
    lock_out && $past(lock_out);
  endsequence
  sequence s_idle2;
    !lock_out && !$past(lock_out);
  endsequence
  a_eq_off: assert property (
    !equalizer_enable |-> equalizer_gain_step == 3'h0 && !serial_test_out_enable) else $error("eq step while off");
  a_spread_off: assert property (
    !spread_enable |-> spread_divider == 12'h0 && spread_dev_step == 2'h0) else $error("spread while off");
  a_div_table: assert property (
    spread_enable |-> spread_divider inside {12'h878, 12'h514, 12'h364, 12'h28A, 12'h26C, 12'h172, 12'h102, 12'h0C0})
    else $error("bad divider");
  a_lock_pass: assert property (
    lock_out |-> pass_out && data_out_oe && recovered_clock_out_oe && status_out_oe && recovered_clock_out_run)
    else $error("locked not driving");
  a_pass_low: assert property (
    !lock_out |-> !pass_out && !recovered_clock_out_run) else $error("pass without lock");
  a_pdown_float: assert property (
    !status_out_oe |-> !data_out_oe && !recovered_clock_out_oe && !lock_out && receiver_sleep) else $error("pdown drive");
  a_data_pass: assert property (
    s_locked2 |-> data_out == $past(recovered_data)) else $error("data not passed");
  a_ctl_pass: assert property (
    s_locked2 |-> control_out == $past(recovered_control)) else $error("control not passed");
  a_phase_idle: assert property (
    s_idle2 |-> !spread_mod_phase) else $error("phase runs while unlocked");
  a_phase_off: assert property (
    !spread_enable && !$past(spread_enable) |-> !spread_mod_phase) else $error("phase runs while off");
  a_idle_low: assert property (
    s_idle2 |-> data_out == 24'h0) else $error("data while unlocked");
  a_lock_awake: assert property (
    lock_out |-> !receiver_sleep) else $error("asleep while locked");
endmodule : dcp_cfg_power_monitor
bind dcp_cfg_power dcp_cfg_power_monitor dcp_cfg_power_monitor_i (.aclk(aclk), .aresetn(aresetn),
  .recovered_data(recovered_data), .recovered_control(recovered_control), .equalizer_enable(equalizer_enable),
  .equalizer_gain_step(equalizer_gain_step),
  .serial_test_out_enable(serial_test_out_enable), .spread_enable(spread_enable), .spread_dev_step(spread_dev_step),
  .spread_divider(spread_divider), .receiver_sleep(receiver_sleep), .data_out(data_out), .control_out(control_out),
  .spread_mod_phase(spread_mod_phase), .recovered_clock_out_run(recovered_clock_out_run), .data_out_oe(data_out_oe),
  .recovered_clock_out_oe(recovered_clock_out_oe), .lock_out(lock_out), .pass_out(pass_out),
  .status_out_oe(status_out_oe));

// ==== sim/dcp_cfg_power_tb.sv ====
// dcp_cfg_power_tb: self-checking bench, axi4-lite host plus pin stimulus
// assumes dcp_ser_model as far end and the monitor bound onto the design
`timescale 1ns/1ps
module dcp_cfg_power_tb;
  import dcp_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} dcp_exp_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hF, seq = 4'h0, ssp = 4'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, pen = 1'b0, run = 1'b0;
  logic scs = 1'b0, sds = 1'b0, slf = 1'b0, sos = 1'b0;
  wire awr, wr, bv, arr, rv, scp, rlk, eqe, toe, cks, dts, spe, sph, rsl, doe, coe, crn, lk, ps, soe;
  wire [1:0] br, rr, sdv;
  wire [31:0] rd;
  wire [23:0] rdat, dout;
  wire [2:0] rctl, eqs, cout;
  wire [11:0] sdi;
  dcp_exp_t rq[$];
  dcp_exp_t ex;
  logic [1:0] bq[$];
  int failures = 0, compares = 0, cyc = 0, i;
  logic [31:0] seed = 32'h8B99C074, r;
  logic [4:0] eqv;
  logic [7:0] ov;
  always #25 aclk = ~aclk;
  dcp_ser_model dcp_ser_model_i (.aclk(aclk), .run(run), .stream_clock_present(scp), .recovery_locked(rlk),
    .recovered_data(rdat), .recovered_control(rctl));
  dcp_cfg_power dcp_cfg_power_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .power_enable_n(pen), .stream_clock_present(scp), .recovery_locked(rlk), .strap_equalizer_select(seq),
    .strap_clock_out_slew_select(scs), .strap_data_out_slew_select(sds), .strap_spread_setting(ssp),
    .strap_low_freq_spread_mode(slf), .strap_output_state_select(sos), .recovered_data(rdat),
    .recovered_control(rctl), .equalizer_enable(eqe), .equalizer_gain_step(eqs), .serial_test_out_enable(toe),
    .clock_out_slew_select(cks), .data_out_slew_select(dts), .spread_enable(spe), .spread_dev_step(sdv),
    .spread_divider(sdi), .spread_mod_phase(sph), .receiver_sleep(rsl), .data_out(dout), .control_out(cout),
    .data_out_oe(doe), .recovered_clock_out_oe(coe), .recovered_clock_out_run(crn), .lock_out(lk),
    .pass_out(ps), .status_out_oe(soe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected status word: lock, powered, sleep, eq fields, spread fields
  function automatic logic [31:0] st(input logic l, p, s, input logic [4:0] e, input logic [3:0] c, input logic f);
    logic [11:0] dv [8] = '{12'h878, 12'h514, 12'h364, 12'h28A, 12'h26C, 12'h172, 12'h102, 12'h0C0};
    logic [3:0] g;
    g = c - 4'h1;
    st = {29'h0, s, p, l};
    st[3] = e[0];
    st[6:4] = e[0] ? e[3:1] : 3'h0;
    if (c != 4'h0) begin
      st[9:8] = g[1:0];
      st[10] = 1'b1;
      st[27:16] = dv[{f, g[3:2]}];
    end
  endfunction : st
  task automatic cmp_w(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_w
  task automatic cmp_r(input string n, input logic [1:0] e, input logic [1:0] s);
    compares++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_r
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // ready is looked at on the falling edge, where it equals its value at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    bq.push_back(e);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      ad = ad | awr;
      dd = dd | wr;
      @(posedge aclk);
      if (ad) awv <= 1'b0;
      if (dd) wv <= 1'b0;
    end
    do @(negedge aclk); while (bv !== 1'b1);
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] e);
    rq.push_back('{d, m, e});
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(negedge aclk); while (arr !== 1'b1);
    @(posedge aclk);
    arv <= 1'b0;
    do @(negedge aclk); while (rv !== 1'b1);
    @(posedge aclk);
  endtask : axr
  // w: 0 locked, 1 asleep but powered, 2 powered down
  task automatic wt(input logic [1:0] w);
    logic met;
    met = 1'b0;
    for (int n = 0; n < 300 && !met; n++) begin
      @(negedge aclk);
      met = (w == 2'd0 && lk === 1'b1) || (w == 2'd1 && rsl === 1'b1 && soe === 1'b1) || (w == 2'd2 && soe === 1'b0);
    end
    if (!met) begin
      failures++;
      $display("mismatch wait state %0d expected reached seen timeout", w);
    end
    @(posedge aclk);
  endtask : wt
  always @(negedge aclk) begin
    if (bv === 1'b1 && bry === 1'b1 && bq.size() > 0) cmp_r("bresp", bq.pop_front(), br);
    if (rv === 1'b1 && rry === 1'b1 && rq.size() > 0) begin
      ex = rq.pop_front();
      cmp_w("rdata", ex.d & ex.m, rd & ex.m);
      cmp_r("rresp", ex.r, rr);
    end
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axw(OFS_EQ_CFG, 32'h1F, RESP_OKAY);
    axr(OFS_EQ_CFG, 32'h0, 32'h1F, RESP_OKAY);
    axr(OFS_STATUS, 32'h0, 32'h0FFFFFFB, RESP_OKAY);
    @(negedge aclk);
    cmp_w("pdown oe", 32'h0, {28'h0, soe, doe, coe, lk});
    @(posedge aclk);
    $display("test power down done");
    seq <= 4'hB;
    scs <= 1'b1;
    ssp <= 4'h6;
    pen <= 1'b1;
    run <= 1'b1;
    wt(2'd0);
    axr(OFS_EQ_CFG, 32'h0B, 32'h1F, RESP_OKAY);
    axr(OFS_OUT_CFG, 32'h61, 32'hFF, RESP_OKAY);
    axr(OFS_STATUS, st(1, 1, 0, 5'h0B, 4'h6, 0), 32'h0FFFFFFF, RESP_OKAY);
    @(negedge aclk);
    cmp_w("mod phase early", 32'h0, {31'h0, sph});
    for (i = 0; i < 1400 && sph !== 1'b1; i++) @(negedge aclk);
    cmp_w("mod phase", 32'h1, {31'h0, sph});
    @(posedge aclk);
    $display("test strap lock done");
    for (i = 0; i < 32; i++) begin
      r = rnd();
      eqv = r[4:0];
      ov = {i[3:0], i[4], 1'b0, r[6:5]};
      axw(OFS_EQ_CFG, {r[31:5], eqv}, RESP_OKAY);
      axw(OFS_OUT_CFG, {24'h0, ov}, RESP_OKAY);
      axr(OFS_STATUS, st(1, 1, 0, eqv, ov[7:4], ov[3]), 32'h0FFFFFFF, RESP_OKAY);
      @(negedge aclk);
      cmp_w("pins", {28'h0, eqv[4] & eqv[0], ov[0], ov[1], ov[7:4] != 4'h0}, {28'h0, toe, cks, dts, spe});
      @(posedge aclk);
    end
    axw(8'h0C, 32'h0, RESP_SLVERR);
    axr(8'h0C, 32'h0, 32'h0, RESP_SLVERR);
    axw(OFS_STATUS, 32'hFFFFFFFF, RESP_OKAY);
    $display("test codes done");
    axw(OFS_OUT_CFG, 32'h34, RESP_OKAY);
    run <= 1'b0;
    wt(2'd1);
    axr(OFS_STATUS, st(0, 1, 1, eqv, 4'h3, 0), 32'h0FFFFFFF, RESP_OKAY);
    axr(OFS_OUT_CFG, 32'h34, 32'hFF, RESP_OKAY);
    @(negedge aclk);
    cmp_w("float oe", 32'h2, {28'h0, doe, coe, soe, lk});
    @(posedge aclk);
    axw(OFS_OUT_CFG, 32'h30, RESP_OKAY);
    @(negedge aclk);
    cmp_w("static oe", 32'hE, {28'h0, doe, coe, soe, lk});
    @(posedge aclk);
    run <= 1'b1;
    wt(2'd0);
    axr(OFS_STATUS, st(1, 1, 0, eqv, 4'h3, 0), 32'h0FFFFFFF, RESP_OKAY);
    $display("test sleep done");
    pen <= 1'b0;
    seq <= 4'h3;
    wt(2'd2);
    axr(OFS_OUT_CFG, 32'h0, 32'hFF, RESP_OKAY);
    axr(OFS_STATUS, 32'h0, 32'h0FFFFFFB, RESP_OKAY);
    pen <= 1'b1;
    wt(2'd0);
    axr(OFS_EQ_CFG, 32'h03, 32'h1F, RESP_OKAY);
    $display("test power cycle done");
    close_out();
  end
endmodule : dcp_cfg_power_tb
